// *** include/adc_cal_sequencer_defines.vh ***
// Purpose: constants for the converter power-up and calibration sequencer
// Assumes: 200 MHz system clock, 4 MHz nominal master clock
// Notes: register offsets are byte addresses on the Avalon-MM slave
`ifndef ADC_CAL_SEQUENCER_DEFINES_VH
`define ADC_CAL_SEQUENCER_DEFINES_VH

// register map
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_IRQ_STATUS 5'h08
`define REG_IRQ_MASK 5'h0c

// control fields
`define CTRL_PMGT_LO 0
`define CTRL_PMGT_HI 1
`define CTRL_CALTYPE_LO 2
`define CTRL_CALTYPE_HI 3
`define CTRL_CALIBRATION_START_BIT 4
`define CTRL_RESET 4'h0

// power management codes {hi, lo}
`define PM_NORMAL 2'h0
`define PM_FULL_AFTER 2'h1
`define PM_FULL_DOWN 2'h2
`define PM_PART_AFTER 2'h3

// calibration types
`define CAL_FULL 2'h0
`define CAL_GAIN_OFFSET 2'h1
`define CAL_OFFSET 2'h2
`define CAL_GAIN 2'h3

// interrupt status bits
`define IRQ_CONV_DONE 0
`define IRQ_CAL_DONE 1
`define IRQ_TIMEOUT_DONE 2

// system clock
`define CLK_PERIOD_NS 5

// times in ns, cycle counts rounded up
`define CONV_FAST_NS 4600
`define CONV_SLOW_NS 9000
`define WAKE_NS 5000
`define CONV_FAST_CYC ((`CONV_FAST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_SLOW_CYC ((`CONV_SLOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// wake-up time, rounded down
`define WAKE_CYC (`WAKE_NS / `CLK_PERIOD_NS)

// master clock durations, times in us at the nominal master clock
`define MCLK_KHZ 4000
`define FULL_CAL_US 31250
`define GO_CAL_US 6940
`define ONE_CAL_US 3470
`define PON_TIMEOUT_US 32000
`define PON_CAL_US 32000
`define FULL_CAL_MCLK (`FULL_CAL_US * `MCLK_KHZ / 1000)
`define GO_CAL_MCLK (`GO_CAL_US * `MCLK_KHZ / 1000)
`define ONE_CAL_MCLK (`ONE_CAL_US * `MCLK_KHZ / 1000)
`define PON_TIMEOUT_MCLK (`PON_TIMEOUT_US * `MCLK_KHZ / 1000)
`define PON_CAL_MCLK (`PON_CAL_US * `MCLK_KHZ / 1000)

`endif

// *** rtl/span_counter.v ***
// Purpose: shared down-counter for timeout and calibration spans
// Assumes: tick is a one-cycle pulse per master clock rising edge
// Notes: done pulses on the tick that empties the count
`timescale 1ns/1ps
module span_counter #(
  parameter WIDTH = 18
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // control
  input wire load,
  input wire [WIDTH-1:0] load_value,
  input wire tick,
  // state
  output wire running,
  output wire done
);

  reg [WIDTH-1:0] count_reg;

  assign running = (count_reg != {WIDTH{1'b0}});
  assign done = tick && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1}) && !load;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (load) begin
      count_reg <= load_value;
    end else if (tick && running) begin
      count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // span_counter

// *** rtl/adc_cal_sequencer.v ***
// Purpose: power-up, power-down and calibration sequencing of a 12-bit ADC
// Assumes: all inputs synchronous to clock; Avalon-MM slave, one wait state
// Notes: spans measured in master clock edges so they scale with its rate
// Notes on behaviour
// - after software power-down, device is ready within 5 us
// - full power-down after conversion powers circuits from the falling strobe until the conversion ends, and while busy
// - conversion lasts 4.6 us fast variant, 9 us low-power variant
// - every calibration except the power-on one starts by writing control with start bit set
// - calibration lengths 31.25, 6.94, 3.47, 3.47 ms at 4 MHz
// - calibration lengths counted in master clock cycles
// - first strobe after power-on starts the 32 ms timeout
// - first strobe raises busy; busy falls when timeout expires
// - next strobe starts full self-calibration, busy high for 32 ms
// - power bits: 00 normal, 01 full after, 10 full down, 11 partial after
// - control write before power-on calibration begins cancels it
// - strobes ignored while busy
`timescale 1ns/1ps
`include "adc_cal_sequencer_defines.vh"
module adc_cal_sequencer #(
  parameter LOW_POWER = 0,
  parameter [17:0] TIMEOUT_MCLK = `PON_TIMEOUT_MCLK,
  parameter [17:0] AUTOCAL_MCLK = `PON_CAL_MCLK,
  parameter [17:0] FULL_CAL_MCLK = `FULL_CAL_MCLK,
  parameter [17:0] GO_CAL_MCLK = `GO_CAL_MCLK,
  parameter [17:0] ONE_CAL_MCLK = `ONE_CAL_MCLK
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // avalon-mm slave
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  // converter pins
  input wire conversion_start_strobe_n,
  input wire master_clock_in,
  output reg busy,
  output reg analog_powered,
  output reg reference_powered,
  // interrupt
  output reg irq
);

  localparam [7:0] S_PON = 8'h01;
  localparam [7:0] S_TMO = 8'h02;
  localparam [7:0] S_ARMED = 8'h04;
  localparam [7:0] S_ACAL = 8'h08;
  localparam [7:0] S_IDLE = 8'h10;
  localparam [7:0] S_CAL = 8'h20;
  localparam [7:0] S_WAKE = 8'h40;
  localparam [7:0] S_CONV = 8'h80;
  localparam [7:0] BUSY_MASK = S_TMO | S_ACAL | S_CAL | S_WAKE | S_CONV;
  // counts worked out at full width, then cut to the counter width on purpose
  localparam integer CONV_CYC_FULL = LOW_POWER ? `CONV_SLOW_CYC : `CONV_FAST_CYC;
  localparam integer WAKE_CYC_FULL = `WAKE_CYC;
  localparam [10:0] CONV_CYC = CONV_CYC_FULL[10:0];
  localparam [10:0] WAKE_CYC = WAKE_CYC_FULL[10:0];

  function [17:0] cal_span;
    input [1:0] kind;
    begin
      case (kind)
        `CAL_FULL: cal_span = FULL_CAL_MCLK;
        `CAL_GAIN_OFFSET: cal_span = GO_CAL_MCLK;
        default: cal_span = ONE_CAL_MCLK;
      endcase
    end
  endfunction

  reg ack_reg;
  reg [7:0] state_reg;
  reg [7:0] state_next;
  reg [3:0] ctrl_reg;
  reg autocal_en_reg;
  reg wake_reg;
  reg [10:0] conv_cnt_reg;
  reg [10:0] pwr_cnt_reg;
  reg [2:0] irq_status_reg;
  reg [2:0] irq_mask_reg;
  reg strobe_q_reg;
  reg mclk_q_reg;
  reg span_load;
  reg [17:0] span_value;
  reg [31:0] read_value;
  wire wr_fire;
  wire rd_fire;
  wire ctrl_write;
  wire calibration_start_bit;
  wire [1:0] pmode;
  wire strobe_fall;
  wire strobe_rise;
  wire mclk_tick;
  wire span_running;
  wire span_done;
  wire ready;
  wire conv_done;
  wire cal_done;
  wire tmo_done;
  wire analog_on;

  // one wait state: data is prepared while waitrequest is high
  assign waitrequest = (read | write) & ~ack_reg;
  assign wr_fire = write & ack_reg;
  assign rd_fire = read & ack_reg;
  assign ctrl_write = wr_fire && (address == `REG_CTRL) && byteenable[0];
  assign calibration_start_bit = ctrl_write && writedata[`CTRL_CALIBRATION_START_BIT];
  assign pmode = {ctrl_reg[`CTRL_PMGT_HI], ctrl_reg[`CTRL_PMGT_LO]};

  // inputs already synchronous, so a single stage serves for edges
  assign strobe_fall = strobe_q_reg & ~conversion_start_strobe_n;
  assign strobe_rise = ~strobe_q_reg & conversion_start_strobe_n;
  assign mclk_tick = ~mclk_q_reg & master_clock_in;

  assign ready = (pwr_cnt_reg == WAKE_CYC);
  assign conv_done = (state_reg == S_CONV) && (conv_cnt_reg == 11'h001);
  assign cal_done = ((state_reg == S_CAL) || (state_reg == S_ACAL)) && span_done;
  assign tmo_done = (state_reg == S_TMO) && span_done;

  span_counter #(
    .WIDTH(18)
  ) u_span (
    .clock(clock),
    .rst(rst),
    .load(span_load),
    .load_value(span_value),
    .tick(mclk_tick),
    .running(span_running),
    .done(span_done)
  );

  always @* begin
    state_next = state_reg;
    span_load = 1'b0;
    span_value = 18'h00000;
    case (state_reg)
      S_PON: begin
        if (calibration_start_bit) begin
          state_next = S_CAL;
          span_load = 1'b1;
          span_value = cal_span(writedata[`CTRL_CALTYPE_HI:`CTRL_CALTYPE_LO]);
        end else if (ctrl_write) begin
          state_next = S_IDLE;
        end else if (strobe_rise) begin
          state_next = S_TMO;
          span_load = 1'b1;
          span_value = TIMEOUT_MCLK;
        end
      end
      S_TMO: begin
        if (tmo_done) begin
          state_next = autocal_en_reg ? S_ARMED : S_IDLE;
        end
      end
      S_ARMED: begin
        if (calibration_start_bit) begin
          state_next = S_CAL;
          span_load = 1'b1;
          span_value = cal_span(writedata[`CTRL_CALTYPE_HI:`CTRL_CALTYPE_LO]);
        end else if (ctrl_write) begin
          state_next = S_IDLE;
        end else if (strobe_rise) begin
          state_next = S_ACAL;
          span_load = 1'b1;
          span_value = AUTOCAL_MCLK;
        end
      end
      S_ACAL, S_CAL: begin
        // a control write here does not abort the running calibration
        if (cal_done) begin
          state_next = S_IDLE;
        end
      end
      S_IDLE: begin
        if (calibration_start_bit) begin
          state_next = S_CAL;
          span_load = 1'b1;
          span_value = cal_span(writedata[`CTRL_CALTYPE_HI:`CTRL_CALTYPE_LO]);
        end else if (strobe_rise && (pmode != `PM_FULL_DOWN)) begin
          state_next = ready ? S_CONV : S_WAKE;
        end
      end
      S_WAKE: begin
        if (ready) begin
          state_next = S_CONV;
        end
      end
      S_CONV: begin
        if (conv_done) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // strobes in busy states never reach a transition above

  // power is on in normal mode, between wake edge and conversion, and while busy
  assign analog_on = (pmode == `PM_NORMAL) || wake_reg ||
                     ((state_reg & BUSY_MASK) != 8'h00);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= S_PON;
      busy <= 1'b0;
      autocal_en_reg <= 1'b1;
      wake_reg <= 1'b0;
      conv_cnt_reg <= 11'h000;
      strobe_q_reg <= 1'b1;
      mclk_q_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy <= ((state_next & BUSY_MASK) != 8'h00);
      strobe_q_reg <= conversion_start_strobe_n;
      mclk_q_reg <= master_clock_in;
      if (ctrl_write) begin
        autocal_en_reg <= 1'b0;
      end
      // falling strobe wakes the part in the after-conversion modes
      if (state_next == S_CONV) begin
        wake_reg <= 1'b0;
      end else if ((state_reg == S_IDLE) && strobe_fall &&
                   ((pmode == `PM_FULL_AFTER) || (pmode == `PM_PART_AFTER))) begin
        wake_reg <= 1'b1;
      end
      if ((state_next == S_CONV) && (state_reg != S_CONV)) begin
        conv_cnt_reg <= CONV_CYC;
      end else if (conv_cnt_reg != 11'h000) begin
        conv_cnt_reg <= conv_cnt_reg - 11'h001;
      end
    end
  end

  // wake-up time counted from power enable; restarts after each power-down
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pwr_cnt_reg <= 11'h000;
      analog_powered <= 1'b0;
      reference_powered <= 1'b0;
    end else begin
      analog_powered <= analog_on;
      reference_powered <= analog_on || (pmode == `PM_PART_AFTER);
      if (!analog_powered) begin
        pwr_cnt_reg <= 11'h000;
      end else if (!ready) begin
        pwr_cnt_reg <= pwr_cnt_reg + 11'h001;
      end
    end
  end

  // register file and interrupt
  always @* begin
    read_value = 32'h00000000;
    case (address)
      `REG_CTRL: read_value = {28'h0000000, ctrl_reg};
      `REG_STATUS: read_value = {16'h0000, state_reg, 2'h0, span_running, autocal_en_reg,
                                 ready, reference_powered, analog_powered, busy};
      `REG_IRQ_STATUS: read_value = {29'h00000000, irq_status_reg};
      `REG_IRQ_MASK: read_value = {29'h00000000, irq_mask_reg};
      default: read_value = 32'h00000000;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      readdata <= 32'h00000000;
      ctrl_reg <= `CTRL_RESET;
      irq_status_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
      if (read && !ack_reg) begin
        readdata <= read_value;
      end
      // start bit is a strobe and is not stored
      if (ctrl_write) begin
        ctrl_reg <= writedata[3:0];
      end
      if (wr_fire && (address == `REG_IRQ_MASK) && byteenable[0]) begin
        irq_mask_reg <= writedata[2:0];
      end
      // clear only what the read returned, so an event while it waits survives; set wins
      irq_status_reg <= (irq_status_reg & ~((rd_fire && (address == `REG_IRQ_STATUS)) ?
                        readdata[2:0] : 3'h0)) | {tmo_done, cal_done, conv_done};
      irq <= ((irq_status_reg & irq_mask_reg) != 3'h0);
    end
  end

endmodule // adc_cal_sequencer

// *** bench/adc_cal_sequencer_sva.sv ***
// Purpose: port checks for the converter sequencer
// Assumes: mode and mask followed from committed byte-0 writes
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
module adc_cal_sequencer_sva (
  // clock and reset
  input wire clock,
  input wire rst,
  // bus
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  // pins
  input wire conversion_start_strobe_n,
  input wire busy,
  input wire analog_powered,
  input wire reference_powered,
  input wire irq
);
  reg [1:0] mode_reg;
  reg [2:0] mask_reg;
  reg [1:0] age_reg;
  wire wr_ok = write && !waitrequest && byteenable[0];
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_reg <= 2'h0;
      mask_reg <= 3'h0;
      age_reg <= 2'h0;
    end else begin
      if (wr_ok && address == 5'h00) mode_reg <= writedata[1:0];
      if (wr_ok && address == 5'h0c) mask_reg <= writedata[2:0];
      if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered after one wait state");
  strobe_busy_a: assert property (age_reg == 2'h3 && mode_reg != 2'h2 && !busy
    && $rose(conversion_start_strobe_n) |-> ##2 busy) else $error("strobe did not raise busy");
  busy_min_a: assert property ($rose(busy) |-> busy[*8])
    else $error("busy span too short");
  mode_off_a: assert property (age_reg == 2'h3 && $past(mode_reg) == 2'h2 && mode_reg == 2'h2
    && !busy && !$past(busy) |-> !analog_powered && !reference_powered)
    else $error("powered in full power-down");
  normal_on_a: assert property (age_reg == 2'h3 && $past(mode_reg) == 2'h0
    && mode_reg == 2'h0 |-> analog_powered && reference_powered) else $error("off in normal mode");
  after_conv_a: assert property (mode_reg == 2'h1 && $fell(busy) |-> ##[1:2] !analog_powered)
    else $error("analog still powered after conversion");
  wake_up_a: assert property (mode_reg == 2'h1 && !busy && $fell(conversion_start_strobe_n)
    |-> ##[1:3] analog_powered) else $error("strobe fall did not power up");
  irq_mask_a: assert property (mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !irq)
    else $error("interrupt with all sources masked");
  read_hi_a: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  cover property (mode_reg == 2'h1 && $fell(busy));
  cover property ($rose(irq));
  cover property (wr_ok && address == 5'h00 && writedata[4]);
endmodule // adc_cal_sequencer_sva

bind adc_cal_sequencer adc_cal_sequencer_sva i_adc_cal_sequencer_sva (.clock(clock), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest),
  .conversion_start_strobe_n(conversion_start_strobe_n), .busy(busy),
  .analog_powered(analog_powered), .reference_powered(reference_powered), .irq(irq));

// *** bench/host_pins_model.sv ***
// Purpose: host side of the converter pins
// Assumes: master clock at one tenth of clock
// Notes: strobe width commanded by the bench
`timescale 1ns/1ps
module host_pins_model (
  // clock and reset
  input wire clock,
  input wire rst,
  // command
  input wire go,
  input wire [15:0] low_len,
  // pins
  output reg conversion_start_strobe_n,
  output reg master_clock_in
);
  reg [15:0] low_cnt_reg;
  reg [2:0] div_reg;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      div_reg <= 3'h0;
      master_clock_in <= 1'b0;
    end else if (div_reg == 3'h4) begin
      div_reg <= 3'h0;
      master_clock_in <= ~master_clock_in;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end
  // fired by go from the bench; strobe held low for low_len clocks
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      low_cnt_reg <= 16'h0000;
      conversion_start_strobe_n <= 1'b1;
    end else if (go) begin
      low_cnt_reg <= low_len;
      conversion_start_strobe_n <= 1'b0;
    end else if (low_cnt_reg != 16'h0000) begin
      low_cnt_reg <= low_cnt_reg - 16'h0001;
      if (low_cnt_reg == 16'h0001) conversion_start_strobe_n <= 1'b1;
    end
  end
endmodule // host_pins_model

// *** bench/test_adc_cal_sequencer.sv ***
// Purpose: self-checking bench for the sequencer
// Assumes: shortened spans 20,20,16,8,4 master edges
// Notes: busy spans counted in clocks, master edge every 10
`timescale 1ns/1ps
module test_adc_cal_sequencer;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg [4:0] address = 5'h00;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg [3:0] byteenable = 4'hf;
  reg go = 1'b0;
  reg [15:0] low_len = 16'h0004;
  wire [31:0] readdata;
  wire waitrequest, busy, analog_powered, reference_powered, irq;
  wire conversion_start_strobe_n, master_clock_in;
  int bad_count = 0;
  int num_checks = 0;
  int len, m;
  int span [4] = '{16, 8, 4, 4};
  reg [31:0] d;
  always #2.5 clock = ~clock;
  adc_cal_sequencer #(.TIMEOUT_MCLK(18'd20), .AUTOCAL_MCLK(18'd20), .FULL_CAL_MCLK(18'd16),
    .GO_CAL_MCLK(18'd8), .ONE_CAL_MCLK(18'd4)) i_adc_cal_sequencer (.clock(clock), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .conversion_start_strobe_n(conversion_start_strobe_n), .master_clock_in(master_clock_in),
    .busy(busy), .analog_powered(analog_powered), .reference_powered(reference_powered),
    .irq(irq));
  host_pins_model i_host_pins_model (.clock(clock), .rst(rst), .go(go), .low_len(low_len),
    .conversion_start_strobe_n(conversion_start_strobe_n), .master_clock_in(master_clock_in));
  task chk(input [31:0] got, input [31:0] lo, input [31:0] hi);
    num_checks++;
    if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task wr(input [4:0] a, input [31:0] v);
    @(posedge clock);
    address <= a;
    writedata <= v;
    write <= 1'b1;
    @(posedge clock iff !waitrequest);
    write <= 1'b0;
  endtask
  task rd(input [4:0] a, output [31:0] q);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    @(posedge clock iff !waitrequest);
    q = readdata;
    read <= 1'b0;
  endtask
  task pulse(input [15:0] w);
    @(posedge clock);
    low_len <= w;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (w) @(posedge clock);
  endtask
  // bounded wait for busy, then its length
  task measure(output int n);
    int k;
    n = 0;
    for (k = 0; k < 12 && busy !== 1'b1; k++) @(negedge clock);
    while (busy === 1'b1) begin
      n++;
      @(negedge clock);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(5'h00, d); chk(d, 0, 0);
    rd(5'h0c, d); chk(d, 0, 0);
    rd(5'h14, d); chk(d, 0, 0);
    rd(5'h04, d); chk(d, 32'h116, 32'h116);
    byteenable <= 4'he;
    wr(5'h0c, 32'h7);
    byteenable <= 4'hf;
    rd(5'h0c, d); chk(d, 0, 0);
    wr(5'h0c, 32'h4);
    pulse(4);
    fork
      measure(len);
      begin
        repeat (80) @(posedge clock);
        pulse(4);
      end
    join
    chk(len, 185, 215);
    repeat (30) @(negedge clock);
    chk(busy, 0, 0);
    chk(irq, 1, 1);
    rd(5'h08, d); chk(d, 4, 4);
    rd(5'h08, d); chk(d, 0, 0);
    $display("test power-on timeout done");
    wr(5'h0c, 32'h2);
    pulse(4);
    measure(len); chk(len, 185, 215);
    rd(5'h08, d); chk(d, 2, 2);
    $display("test power-on calibration done");
    for (m = 0; m < 4; m++) begin
      wr(5'h00, 32'h10 | (m << 2));
      measure(len); chk(len, span[m] * 10 - 10, span[m] * 10 + 15);
      rd(5'h00, d); chk(d, m << 2, m << 2);
      rd(5'h08, d); chk(d, 2, 2);
    end
    $display("test software calibration done");
    wr(5'h0c, 32'h1);
    for (m = 0; m < 4; m++) begin
      wr(5'h00, m);
      pulse(1100);
      measure(len); chk(len, (m == 2) ? 0 : 919, (m == 2) ? 0 : 921);
      repeat (4) @(negedge clock);
      chk(analog_powered, m == 0, m == 0);
      chk(reference_powered, m == 0 || m == 3, m == 0 || m == 3);
      chk(irq, m != 2, m != 2);
      rd(5'h08, d); chk(d, m != 2, m != 2);
    end
    wr(5'h00, 32'h1);
    pulse(4);
    measure(len); chk(len, 1910, 1925);
    $display("test power modes done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    wr(5'h00, 32'h0);
    repeat (1100) @(posedge clock);
    pulse(4);
    measure(len); chk(len, 919, 921);
    $display("test calibration cancel done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    pulse(4);
    repeat (40) @(posedge clock);
    wr(5'h00, 32'h0);
    measure(len); chk(len, 140, 165);
    repeat (1100) @(posedge clock);
    pulse(4);
    measure(len); chk(len, 919, 921);
    $display("test timeout cancel done");
    stop_test;
  end
endmodule // test_adc_cal_sequencer
